// *** rtl/instruction_sequencer_stack.sv ***
// Behaviour
// [RULE1] four one-hot phases form one instruction cycle
// [RULE2] address advances, fetch in first phase
// [RULE3] fetch overlaps execution, one per cycle
// [RULE4] branches take two cycles
// [RULE5] extended ops two cycles, branches one more
// [RULE6] address increments unless control transfers
// [RULE7] 12/13-bit counter plus bank bits
// [RULE8] only low address byte software visible
// [RULE9] low byte write jumps in page, dummy cycle
// [RULE10] destinations load directly into address register
// [RULE11] true skip discards fetched word, dummy cycle
// [RULE12] return stack hidden from software
// [RULE13] call/interrupt push, both returns pop
// [RULE14] reset points stack at top
// [RULE15] full stack holds interrupt until a return
// [RULE16] call on full stack drops oldest entry
// [RULE17] stack depth parameter 8, 12 or 16
// [RULE18] 8-bit ALU through the accumulator
// [RULE19] ALU writes result and updates flags
// [RULE20] add/sub/daa/logic/rotate/inc/dec-skip supported
// [RULE21] reset starts at address zero
// [RULE22] low byte write keeps upper and bank bits
`default_nettype none
module instruction_sequencer_stack
	import seq_pkg::*;
#(
	parameter int PC_W        = 13,
	parameter int BANK_W      = 2,
	parameter int STACK_DEPTH = 8,
	parameter int INT_VECTOR  = 4
) (
	// clock and reset
	input  wire logic                   I_MCLK,
	input  wire logic                   I_RSTN,
	// program memory
	output logic [BANK_W+PC_W-1:0]      O_PROG_ADDR,
	input  wire logic [WORD_W-1:0]      I_PROG_WORD,
	// phases
	output logic [3:0]                  O_PHASE,
	// interrupt
	input  wire logic                   I_INT_REQ,
	output logic                        O_INT_ACK,
	// register port
	input  wire logic [REG_ADDR_W-1:0]  I_REG_ADDR,
	input  wire logic [7:0]             I_REG_WDATA,
	input  wire logic                   I_REG_WR,
	input  wire logic                   I_REG_RD,
	output logic [7:0]                  O_REG_RDATA
);
	// [RULE17] stack sized by the depth parameter
	localparam int                SP_W     = $clog2(STACK_DEPTH);
	localparam logic [PC_W-1:0]   pc_rst   = PC_W'(RESET_ADDR);
	localparam logic [PC_W-1:0]   int_vec  = PC_W'(INT_VECTOR);
	localparam logic [PC_W-1:0]   tgt_mask = PC_W'(TGT_LOW_MASK);
	localparam logic [PC_W-1:0]   pc_one   = PC_W'(1);
	localparam logic [SP_W:0]     full_cnt = (SP_W+1)'(STACK_DEPTH);
	localparam logic [SP_W-1:0]   last_idx = SP_W'(STACK_DEPTH - 1);

	logic [3:0]             phase_ff;
	logic [PC_W-1:0]        pc_ff;
	logic [PC_W-1:0]        nxt_pc;
	logic [BANK_W-1:0]      bank_ff;
	logic [WORD_W-1:0]      fetch_ff;
	logic [WORD_W-1:0]      ir_ff;
	logic                   ir_valid_ff;
	logic                   ext_done_ff;
	logic [7:0]             acc_ff;
	logic [7:0]             data_ff;
	logic [ST_W-1:0]        status_ff;
	logic                   int_en_ff;
	logic                   int_flag_ff;
	logic                   int_ack_ff;
	logic                   page_pend_ff;
	logic [7:0]             page_byte_ff;
	logic [7:0]             rdata_ff;
	logic [PC_W-1:0]        stack_ff [STACK_DEPTH];
	logic [SP_W-1:0]        top_ff;
	logic [SP_W:0]          count_ff;

	logic                   step;
	logic                   ext_stall;
	logic                   exec;
	opcode_t                op;
	alu_op_t                aop;
	logic [7:0]             alu_a;
	logic [7:0]             alu_b;
	logic [10:0]            alu_out;
	logic [7:0]             alu_res;
	logic                   alu_zero;
	logic                   wr_acc;
	logic                   wr_data;
	logic                   wr_flags;
	logic                   skip_take;
	logic                   do_jump;
	logic                   do_push;
	logic                   do_pop;
	logic                   int_take;
	logic                   flush;
	logic                   stack_full;
	logic [PC_W-1:0]        return_addr;
	logic [PC_W-1:0]        branch_tgt;

	// wrap-around stack index arithmetic for any depth
	function automatic logic [SP_W-1:0] idx_inc(input logic [SP_W-1:0] i);
		return (i == last_idx) ? '0 : i + SP_W'(1);
	endfunction

	function automatic logic [SP_W-1:0] idx_dec(input logic [SP_W-1:0] i);
		return (i == '0) ? last_idx : i - SP_W'(1);
	endfunction

	// returns {ov, ac, c, result}
	function automatic logic [10:0] alu_calc(input alu_op_t o, input logic [7:0] a,
			input logic [7:0] b, input logic cin, input logic acin);
		logic [8:0] s;
		logic [4:0] h;
		logic       cy;
		logic       c;
		logic       ac;
		logic       ov;
		logic [7:0] r;
		s  = '0;
		h  = '0;
		cy = 1'b0;
		c  = cin;
		ac = acin;
		ov = 1'b0;
		r  = a;
		case (o)
			ALU_ADD, ALU_ADC: begin
				cy = (o == ALU_ADC) ? cin : 1'b0;
				s  = {1'b0, a} + {1'b0, b} + {8'h00, cy};
				h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
				r  = s[7:0];
				c  = s[8];
				ac = h[4];
				ov = (a[7] == b[7]) && (r[7] != a[7]);
			end
			ALU_SUB, ALU_SBC: begin
				// carry set means no borrow
				cy = (o == ALU_SBC) ? cin : 1'b1;
				s  = {1'b0, a} + {1'b0, ~b} + {8'h00, cy};
				h  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cy};
				r  = s[7:0];
				c  = s[8];
				ac = h[4];
				ov = (a[7] != b[7]) && (r[7] != a[7]);
			end
			ALU_DAA: begin
				s = {1'b0, a};
				if ((a[3:0] > 4'h9) || acin) begin
					s = s + 9'h006;
				end
				if ((s[7:4] > 4'h9) || cin || s[8]) begin
					s = s + 9'h060;
				end
				r = s[7:0];
				c = s[8] | cin;
			end
			ALU_AND: r = a & b;
			ALU_OR:  r = a | b;
			ALU_XOR: r = a ^ b;
			ALU_CPL: r = ~a;
			ALU_RR:  r = {a[0], a[7:1]};
			ALU_RRC: begin
				r = {cin, a[7:1]};
				c = a[0];
			end
			ALU_RL:  r = {a[6:0], a[7]};
			ALU_RLC: begin
				r = {a[6:0], cin};
				c = a[7];
			end
			ALU_INC: r = a + 8'h01;
			ALU_DEC: r = a - 8'h01;
			ALU_MOV: r = b;
			default: r = a;
		endcase
		return {ov, ac, c, r};
	endfunction

	// [RULE1] phase sequencer
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			phase_ff <= RST_PHASE;
		end else begin
			phase_ff <= {phase_ff[2:0], phase_ff[3]};
		end
	end

	assign step       = phase_ff[PH_LAST];
	assign op         = opcode_t'(ir_ff[OPC_HI:OPC_LO]);
	assign aop        = alu_op_t'(ir_ff[ALU_HI:ALU_LO]);
	assign stack_full = (count_ff == full_cnt);
	assign return_addr = stack_ff[idx_dec(top_ff)];
	assign branch_tgt  = (pc_ff & ~tgt_mask) | (PC_W'(ir_ff[TGT_HI:0]) & tgt_mask);

	// [RULE5] extended op holds one extra cycle
	assign ext_stall = ir_valid_ff && (op == OP_EXT_ALU) && !ext_done_ff;
	assign exec      = step && ir_valid_ff && !ext_stall;

	// [RULE18] operand routing through accumulator
	always_comb begin
		alu_a = acc_ff;
		alu_b = ir_ff[IMM_HI:0];
		case (op)
			OP_ALU_MEM: begin
				alu_a = data_ff;
				alu_b = acc_ff;
			end
			OP_INC_SKIP, OP_DEC_SKIP, OP_SKIP_ZERO, OP_SKIP_NZ: begin
				alu_a = data_ff;
			end
			default: begin
				alu_a = acc_ff;
			end
		endcase
	end

	// [RULE20] operation selection
	always_comb begin
		case (op)
			OP_INC_SKIP:             alu_out = alu_calc(ALU_INC, alu_a, alu_b,
				status_ff[ST_C], status_ff[ST_AC]);
			OP_DEC_SKIP:             alu_out = alu_calc(ALU_DEC, alu_a, alu_b,
				status_ff[ST_C], status_ff[ST_AC]);
			OP_SKIP_ZERO, OP_SKIP_NZ: alu_out = alu_calc(ALU_MOV, alu_a, alu_a,
				status_ff[ST_C], status_ff[ST_AC]);
			default:                 alu_out = alu_calc(aop, alu_a, alu_b,
				status_ff[ST_C], status_ff[ST_AC]);
		endcase
	end

	assign alu_res  = alu_out[7:0];
	assign alu_zero = (alu_res == 8'h00);

	// instruction decode
	always_comb begin
		wr_acc    = 1'b0;
		wr_data   = 1'b0;
		wr_flags  = 1'b0;
		skip_take = 1'b0;
		do_jump   = 1'b0;
		do_push   = 1'b0;
		do_pop    = 1'b0;
		if (exec) begin
			case (op)
				OP_ALU_ACC, OP_EXT_ALU: begin
					wr_acc   = 1'b1;
					wr_flags = 1'b1;
				end
				OP_ALU_MEM: begin
					wr_data  = 1'b1;
					wr_flags = 1'b1;
				end
				// [RULE20] increment or decrement and skip on zero
				OP_INC_SKIP, OP_DEC_SKIP: begin
					wr_data   = 1'b1;
					skip_take = alu_zero;
				end
				OP_SKIP_ZERO: skip_take = alu_zero;
				OP_SKIP_NZ:   skip_take = !alu_zero;
				OP_JUMP:      do_jump = 1'b1;
				// [RULE13] call pushes
				OP_CALL: begin
					do_jump = 1'b1;
					do_push = 1'b1;
				end
				// [RULE13] both returns pop
				OP_SUB_RETURN, OP_INT_RETURN: begin
					do_jump = 1'b1;
					do_pop  = 1'b1;
				end
				default: begin
					wr_acc = 1'b0;
				end
			endcase
		end
	end

	// [RULE15] no acknowledge while the stack is full
	assign int_take = step && int_flag_ff && int_en_ff && !stack_full && !ext_stall
		&& !do_jump && !skip_take && !page_pend_ff;

	// [RULE11] skip, branch, page jump or interrupt all drop the fetched word
	assign flush = do_jump || skip_take || int_take || (step && page_pend_ff && !ext_stall);

	// [RULE6] next program address
	always_comb begin
		nxt_pc = pc_ff + pc_one;
		if (ext_stall) begin
			nxt_pc = pc_ff;
		end else if (do_pop) begin
			nxt_pc = return_addr;
		end else if (do_jump) begin
			// [RULE10] direct load of destination
			nxt_pc = branch_tgt;
		end else if (page_pend_ff) begin
			// [RULE22] page jump keeps upper bits
			nxt_pc = {pc_ff[PC_W-1:8], page_byte_ff};
		end else if (int_take) begin
			nxt_pc = int_vec;
		end
	end

	// [RULE2] address update at start of first phase
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			// [RULE21] start at address zero
			pc_ff <= pc_rst;
		end else if (step) begin
			pc_ff <= nxt_pc;
		end
	end

	// [RULE2] fetch during first phase
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			fetch_ff <= '0;
		end else if (phase_ff[PH_FETCH]) begin
			fetch_ff <= I_PROG_WORD;
		end
	end

	// [RULE3] pipeline register, [RULE4] flushed word becomes a dummy cycle
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ir_ff       <= '0;
			ir_valid_ff <= 1'b0;
			ext_done_ff <= 1'b0;
		end else if (step) begin
			ext_done_ff <= ext_stall;
			if (!ext_stall) begin
				ir_ff       <= fetch_ff;
				ir_valid_ff <= !flush;
			end
		end
	end

	// [RULE12] stack storage, reachable by no register
	always_ff @(posedge I_MCLK) begin
		if (do_push || int_take) begin
			stack_ff[top_ff] <= pc_ff;
		end
	end

	// [RULE14] pointer at top after reset, [RULE16] oldest entry overwritten
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			top_ff   <= '0;
			count_ff <= '0;
		end else if (do_push || int_take) begin
			top_ff <= idx_inc(top_ff);
			if (!stack_full) begin
				count_ff <= count_ff + (SP_W+1)'(1);
			end
		end else if (do_pop) begin
			top_ff <= idx_dec(top_ff);
			if (count_ff != '0) begin
				count_ff <= count_ff - (SP_W+1)'(1);
			end
		end
	end

	// [RULE15] request latched, set wins over acknowledge
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			int_flag_ff <= 1'b0;
		end else if (I_INT_REQ) begin
			int_flag_ff <= 1'b1;
		end else if (int_take) begin
			int_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			int_ack_ff <= 1'b0;
		end else begin
			int_ack_ff <= int_take;
		end
	end

	// interrupt enable: cleared on acknowledge, set by interrupt return
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			int_en_ff <= 1'b0;
		end else if (int_take) begin
			int_en_ff <= 1'b0;
		end else if (do_pop && (op == OP_INT_RETURN)) begin
			int_en_ff <= 1'b1;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_CTRL)) begin
			int_en_ff <= I_REG_WDATA[CTRL_INT_EN];
		end
	end

	// [RULE9] low byte write queues a page jump
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			page_pend_ff <= 1'b0;
			page_byte_ff <= RST_BYTE;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_PC_LOW)) begin
			page_pend_ff <= 1'b1;
			page_byte_ff <= I_REG_WDATA;
		end else if (step && !ext_stall) begin
			page_pend_ff <= 1'b0;
		end
	end

	// [RULE7] bank select bits above the counter
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			bank_ff <= '0;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_BANK)) begin
			bank_ff <= I_REG_WDATA[BANK_W-1:0];
		end
	end

	// [RULE19] result to accumulator
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			acc_ff <= RST_BYTE;
		end else if (wr_acc) begin
			acc_ff <= alu_res;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_ACC)) begin
			acc_ff <= I_REG_WDATA;
		end
	end

	// [RULE19] result to data register
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			data_ff <= RST_BYTE;
		end else if (wr_data) begin
			data_ff <= alu_res;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_DATA)) begin
			data_ff <= I_REG_WDATA;
		end
	end

	// [RULE19] flag update
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			status_ff <= RST_STATUS;
		end else if (wr_flags) begin
			status_ff <= {alu_out[10], alu_zero, alu_out[9:8]};
		end else if (wr_data) begin
			status_ff[ST_Z] <= alu_zero;
		end else if (I_REG_WR && (I_REG_ADDR == OFS_STATUS)) begin
			status_ff <= I_REG_WDATA[ST_W-1:0];
		end
	end

	// [RULE8] read port, only the low address byte exposed
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_ff <= RST_BYTE;
		end else if (I_REG_RD) begin
			case (I_REG_ADDR)
				OFS_PC_LOW: rdata_ff <= pc_ff[7:0];
				OFS_ACC:    rdata_ff <= acc_ff;
				OFS_STATUS: rdata_ff <= 8'(status_ff);
				OFS_DATA:   rdata_ff <= data_ff;
				OFS_CTRL:   rdata_ff <= 8'(int_en_ff);
				OFS_BANK:   rdata_ff <= 8'(bank_ff);
				default:    rdata_ff <= RST_BYTE;
			endcase
		end else begin
			rdata_ff <= RST_BYTE;
		end
	end

	// [RULE7] bank bits prepended to the program address
	assign O_PROG_ADDR = {bank_ff, pc_ff};
	assign O_PHASE     = phase_ff;
	assign O_INT_ACK   = int_ack_ff;
	assign O_REG_RDATA = rdata_ff;
endmodule
`default_nettype wire

// *** rtl/seq_pkg.sv ***
`default_nettype none
package seq_pkg;
	// register map, byte-wide registers on the plain register port
	localparam int              REG_ADDR_W     = 3;
	localparam logic [2:0]      OFS_PC_LOW     = 3'h0;
	localparam logic [2:0]      OFS_ACC        = 3'h1;
	localparam logic [2:0]      OFS_STATUS     = 3'h2;
	localparam logic [2:0]      OFS_DATA       = 3'h3;
	localparam logic [2:0]      OFS_CTRL       = 3'h4;
	localparam logic [2:0]      OFS_BANK       = 3'h5;
	// status and control fields
	localparam int              ST_W           = 4;
	localparam int              ST_C           = 0;
	localparam int              ST_AC          = 1;
	localparam int              ST_Z           = 2;
	localparam int              ST_OV          = 3;
	localparam int              CTRL_INT_EN    = 0;
	// reset values
	localparam logic [7:0]      RST_BYTE       = 8'h00;
	localparam logic [ST_W-1:0] RST_STATUS     = 4'h0;
	localparam logic [3:0]      RST_PHASE      = 4'h1;
	localparam int              RESET_ADDR     = 0;
	// instruction word layout
	localparam int              WORD_W         = 16;
	localparam int              OPC_HI         = 15;
	localparam int              OPC_LO         = 12;
	localparam int              ALU_HI         = 11;
	localparam int              ALU_LO         = 8;
	localparam int              IMM_HI         = 7;
	localparam int              TGT_HI         = 11;
	localparam int              TGT_LOW_MASK   = 'hfff;
	// phase positions in the one-hot phase vector
	localparam int              PH_FETCH       = 0;
	localparam int              PH_LAST        = 3;

	typedef enum logic [3:0] {
		OP_NOP, OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_ALU_ACC, OP_ALU_MEM,
		OP_INC_SKIP, OP_DEC_SKIP, OP_SKIP_ZERO, OP_SKIP_NZ, OP_EXT_ALU
	} opcode_t;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
		ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
	} alu_op_t;
endpackage
`default_nettype wire

// *** tb/seq_props.sv ***
`default_nettype none
module seq_props
	import seq_pkg::*;
#(
	parameter int PC_W       = 13,
	parameter int BANK_W     = 2,
	parameter int INT_VECTOR = 4
) (
	// clock and reset
	input wire logic                   I_MCLK,
	input wire logic                   I_RSTN,
	// watched ports
	input wire logic [BANK_W+PC_W-1:0] O_PROG_ADDR,
	input wire logic [3:0]             O_PHASE,
	input wire logic                   O_INT_ACK,
	input wire logic [REG_ADDR_W-1:0]  I_REG_ADDR,
	input wire logic                   I_REG_RD,
	input wire logic [7:0]             O_REG_RDATA
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);

	AST_PHASE_ONEHOT: assert property ($onehot(O_PHASE))
		else $error("phase not one-hot");
	AST_PHASE_ROT: assert property (I_RSTN && O_PHASE != 4'h0 |=>
		O_PHASE == {$past(O_PHASE[2:0]), $past(O_PHASE[3])}) else $error("phase skipped");
	AST_ADDR_AT_STEP: assert property ($changed(O_PROG_ADDR) |-> $past(O_PHASE) == 4'h8)
		else $error("address moved outside last phase");
	AST_ADDR_HOLD: assert property (O_PHASE == 4'h1 |=> $stable(O_PROG_ADDR) [*3])
		else $error("address not held for a cycle");
	AST_RDATA_IDLE: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 8'h00)
		else $error("read data outside read slot");
	AST_PC_LOW_READ: assert property (I_REG_RD && I_REG_ADDR == OFS_PC_LOW |=>
		O_REG_RDATA == $past(O_PROG_ADDR[7:0])) else $error("low address byte read wrong");
	AST_HIDDEN: assert property (I_REG_RD && I_REG_ADDR > OFS_BANK |=> O_REG_RDATA == 8'h00)
		else $error("unmapped index returned data");
	AST_ACK_VECTOR: assert property (O_INT_ACK |->
		O_PROG_ADDR[PC_W-1:0] == PC_W'(INT_VECTOR) && $past(O_PHASE) == 4'h8)
		else $error("acknowledge without vector load");
	AST_ACK_PULSE: assert property (O_INT_ACK |=> !O_INT_ACK [*3])
		else $error("acknowledge longer than a pulse");
endmodule
`default_nettype wire

// *** tb/prog_mem_model.sv ***
`default_nettype none
module prog_mem_model
	import seq_pkg::*;
#(
	parameter int AW = 15
) (
	// fetch port
	input  wire logic [AW-1:0] i_addr,
	output logic [WORD_W-1:0]  o_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// combinational program store, unused words are no-ops
	always_comb begin
		o_word = {OP_NOP, 12'h000};
		case (i_addr)
			15'h000: o_word = {OP_ALU_ACC, ALU_MOV, 8'h05};
			15'h001: o_word = {OP_ALU_ACC, ALU_ADD, 8'hfb};
			15'h002: o_word = {OP_JUMP, 12'h010};
			15'h004: o_word = {OP_INT_RETURN, 12'h000};
			15'h010: o_word = {OP_CALL, 12'h020};
			15'h012: o_word = {OP_SKIP_ZERO, 12'h000};
			15'h013: o_word = {OP_ALU_ACC, ALU_ADD, 8'h01};
			15'h014: o_word = {OP_SKIP_NZ, 12'h000};
			15'h015: o_word = {OP_JUMP, 12'h118};
			15'h020: o_word = {OP_SUB_RETURN, 12'h000};
			15'h119: o_word = {OP_JUMP, 12'h118};
			15'h141: o_word = {OP_JUMP, 12'h140};
			15'h169: o_word = {OP_JUMP, 12'h168};
			15'h16a: o_word = {OP_SUB_RETURN, 12'h000};
			default: if (i_addr >= 15'h160 && i_addr <= 15'h167) begin
				o_word = {OP_CALL, i_addr[11:0] + 12'h001};
			end
		endcase
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench
	import seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  mclk;
	logic                  rstn;
	logic [14:0]           prog_addr;
	logic [WORD_W-1:0]     prog_word;
	logic [3:0]            phase;
	logic                  int_req;
	logic                  int_ack;
	logic [REG_ADDR_W-1:0] reg_addr;
	logic [7:0]            reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [7:0]            reg_rdata;
	logic [7:0]            rd;
	int                    num_errors = 0;
	int                    comparisons = 0;
	int                    cycles = 0;
	logic [14:0]           fetched[$];
	logic [14:0]           exp_fetch[17] = '{15'h000, 15'h001, 15'h002, 15'h003, 15'h010,
		15'h011, 15'h020, 15'h021, 15'h011, 15'h012, 15'h013, 15'h014, 15'h015,
		15'h016, 15'h118, 15'h119, 15'h11a};

	instruction_sequencer_stack #(
		.PC_W       (13),
		.BANK_W     (2),
		.STACK_DEPTH(8),
		.INT_VECTOR (4)
	) DUT (
		.I_MCLK     (mclk),
		.I_RSTN     (rstn),
		.O_PROG_ADDR(prog_addr),
		.I_PROG_WORD(prog_word),
		.O_PHASE    (phase),
		.I_INT_REQ  (int_req),
		.O_INT_ACK  (int_ack),
		.I_REG_ADDR (reg_addr),
		.I_REG_WDATA(reg_wdata),
		.I_REG_WR   (reg_wr),
		.I_REG_RD   (reg_rd),
		.O_REG_RDATA(reg_rdata)
	);

	prog_mem_model #(.AW(15)) u_mem (.i_addr(prog_addr), .o_word(prog_word));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// fetch trace, one entry per fetch phase for the first 17 fetches after reset release
	always @(posedge mclk) begin
		cycles++;
		if (rstn === 1'b1 && phase === 4'h1 && fetched.size() < 17) begin
			fetched.push_back(prog_addr);
		end
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_rd_t(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	task automatic wait_fetch(input logic [14:0] a);
		int n;
		n = 0;
		while (!(prog_addr === a && phase === 4'h1) && n < 400) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 400, "fetch address not reached");
	endtask

	task automatic wait_ack(input logic want, input int lim);
		logic seen;
		seen = 1'b0;
		repeat (lim) begin
			@(negedge mclk);
			seen = seen | int_ack;
		end
		chk(seen === want, "interrupt acknowledge wrong");
	endtask

	task automatic pulse_int();
		@(posedge mclk);
		int_req <= 1'b1;
		@(posedge mclk);
		int_req <= 1'b0;
	endtask

	// write the low address byte while the loop's no-op executes
	task automatic page_jump(input logic [14:0] trig, input logic [7:0] low);
		wait_fetch(trig);
		reg_wr_t(OFS_PC_LOW, low);
	endtask

	task automatic t_reset();
		@(negedge mclk);
		chk(phase === 4'h1 && prog_addr === 15'h000, "reset state wrong");
	endtask

	task automatic t_pipeline();
		wait_fetch(15'h11a);
		repeat (4) @(negedge mclk);
		foreach (exp_fetch[i]) chk(fetched[i] === exp_fetch[i], "fetch order");
		reg_rd_t(OFS_ACC, rd);
		chk(rd === 8'h00, "accumulator after add");
		reg_rd_t(OFS_STATUS, rd);
		chk(rd[ST_C] === 1'b1 && rd[ST_Z] === 1'b1, "carry or zero flag");
	endtask

	task automatic t_regs();
		reg_rd_t(OFS_PC_LOW, rd);
		chk(rd >= 8'h18 && rd <= 8'h1a, "low address byte");
		reg_wr_t(OFS_DATA, 8'h5a);
		reg_rd_t(OFS_DATA, rd);
		chk(rd === 8'h5a, "data register");
		reg_rd_t(OFS_BANK, rd);
		chk(rd === 8'h00, "bank select reset");
		reg_wr_t(3'h7, 8'hff);
		reg_rd_t(3'h7, rd);
		chk(rd === 8'h00, "unmapped index");
		reg_rd_t(3'h6, rd);
		chk(rd === 8'h00, "unmapped index");
	endtask

	task automatic t_page();
		page_jump(15'h119, 8'h40);
		wait_fetch(15'h140);
	endtask

	task automatic t_int();
		reg_wr_t(OFS_CTRL, 8'h01);
		pulse_int();
		wait_ack(1'b1, 40);
		wait_fetch(15'h141);
		reg_rd_t(OFS_CTRL, rd);
		chk(rd[CTRL_INT_EN] === 1'b1, "enable after return");
	endtask

	task automatic t_stack();
		page_jump(15'h141, 8'h60);
		wait_fetch(15'h169);
		pulse_int();
		wait_ack(1'b0, 60);
		page_jump(15'h169, 8'h6a);
		wait_ack(1'b1, 40);
	endtask

	task automatic t_reset2();
		@(posedge mclk);
		rstn <= 1'b0;
		t_reset();
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		wait_fetch(15'h001);
	endtask

	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		int_req = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (5) @(posedge mclk);
		t_reset();
		@(posedge mclk);
		rstn <= 1'b1;
		t_pipeline();
		t_regs();
		t_page();
		t_int();
		t_stack();
		t_reset2();
		finish_test();
	end
endmodule

bind instruction_sequencer_stack seq_props #(
	.PC_W      (PC_W),
	.BANK_W    (BANK_W),
	.INT_VECTOR(INT_VECTOR)
) u_props (
	.I_MCLK     (I_MCLK),
	.I_RSTN     (I_RSTN),
	.O_PROG_ADDR(O_PROG_ADDR),
	.O_PHASE    (O_PHASE),
	.O_INT_ACK  (O_INT_ACK),
	.I_REG_ADDR (I_REG_ADDR),
	.I_REG_RD   (I_REG_RD),
	.O_REG_RDATA(O_REG_RDATA)
);
`default_nettype wire
